// ===== tta_top.sv
// Thermal throttle assertion timer, limit compare, fan override and alert
`timescale 1ns/100ps
`default_nettype none
module tta_top #(
    parameter int TICK_CYCLES = tta_pkg::TTA_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [7:0]           reg_wdata_i,
    output var  logic [7:0]           reg_rdata_o,
    // Multi-purpose pin
    input  wire logic                 multi_pin_i,
    output var  logic                 multi_pin_o,
    output var  logic                 multi_pin_oe_n_o,
    // Dedicated alert pin
    output var  logic                 alert_pin_o,
    output var  logic                 alert_pin_oe_n_o,
    // Fan state
    input  wire logic [7:0]           fan_manual_duty_i,
    input  wire logic                 fan_auto_mode_i,
    input  wire logic                 fan_above_start_i,
    output var  logic                 full_speed_override_o,
    // Observed state
    output var  logic                 fan4_or_throttle_flag_o
);
    import tta_pkg::*;

    // ==============================
    // Registers
    logic [7:0]   config_three;
    logic [7:0]   throttle_timer_limit;
    logic [7:0]   mask_two;
    logic [1:0]   multi_pin_select;
    logic [7:0]   next_config_three;
    logic [7:0]   next_throttle_timer_limit;
    logic [7:0]   next_mask_two;
    logic [1:0]   next_multi_pin_select;

    logic         wr_c3;
    logic         wr_lim;
    logic         wr_mask;
    logic         wr_c4;
    logic         rd_timer;
    logic         rd_status;

    // Strobe qualified by one register address
    function automatic logic reg_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    assign wr_c3     = reg_hit(reg_wr_i, reg_addr_i, TTA_ADDR_CONFIG_THREE);
    assign wr_lim    = reg_hit(reg_wr_i, reg_addr_i, TTA_ADDR_TIMER_LIMIT);
    assign wr_mask   = reg_hit(reg_wr_i, reg_addr_i, TTA_ADDR_MASK_TWO);
    assign wr_c4     = reg_hit(reg_wr_i, reg_addr_i, TTA_ADDR_CONFIG_FOUR);
    assign rd_timer  = reg_hit(reg_rd_i, reg_addr_i, TTA_ADDR_TIMER);
    assign rd_status = reg_hit(reg_rd_i, reg_addr_i, TTA_ADDR_STATUS_TWO);

    always_comb begin
        next_config_three         = wr_c3   ? reg_wdata_i : config_three;
        next_throttle_timer_limit = wr_lim  ? reg_wdata_i : throttle_timer_limit;
        next_mask_two             = wr_mask ? reg_wdata_i : mask_two;
        next_multi_pin_select     = wr_c4   ? reg_wdata_i[TTA_SEL_MSB:TTA_SEL_LSB]
                                            : multi_pin_select;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            config_three         <= TTA_RST_BYTE;
            throttle_timer_limit <= TTA_RST_BYTE;
            mask_two             <= TTA_RST_BYTE;
            multi_pin_select     <= TTA_PIN_TACH;
        end else begin
            config_three         <= next_config_three;
            throttle_timer_limit <= next_throttle_timer_limit;
            mask_two             <= next_mask_two;
            multi_pin_select     <= next_multi_pin_select;
        end
    end

    // ==============================
    // Pin function decode and input synchroniser
    logic pin_is_throttle;
    logic pin_is_alert;
    logic monitor_en;
    logic sync_a;
    logic sync_b;
    logic next_sync_a;
    logic next_sync_b;
    logic thermal_throttle_n;
    logic asserted;

    assign pin_is_throttle = (multi_pin_select == TTA_PIN_THROTTLE);
    assign pin_is_alert    = (multi_pin_select == TTA_PIN_ALERT);
    assign monitor_en      = pin_is_throttle && config_three[TTA_C3_TIMER_EN_BIT];
    assign thermal_throttle_n = sync_b;
    assign asserted        = monitor_en && !thermal_throttle_n;

    always_comb begin
        next_sync_a = multi_pin_i;
        next_sync_b = sync_a;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ==============================
    // Assertion timer
    tta_presc_if presc ();

    tta_prescaler #(
        .TICK_CYCLES (TICK_CYCLES),
        .CNT_W       (TTA_PRESC_W)
    ) u_presc (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .presc   (presc.master)
    );

    assign presc.run   = asserted;
    assign presc.clear = rd_timer;

    logic [7:0] throttle_assert_timer;
    logic [7:0] next_throttle_assert_timer;
    logic       first_step;
    logic       next_first_step;
    logic       timer_empty;
    logic       timer_full;
    logic       timer_at_one;

    assign timer_empty  = (throttle_assert_timer == TTA_RST_BYTE);
    assign timer_full   = (throttle_assert_timer == TTA_TIMER_FULL);
    assign timer_at_one = (throttle_assert_timer == TTA_TIMER_ONE);

    always_comb begin
        next_throttle_assert_timer = throttle_assert_timer;
        next_first_step            = first_step;
        if (rd_timer) begin
            next_throttle_assert_timer = asserted ? TTA_TIMER_ONE : TTA_RST_BYTE;
            next_first_step            = 1'b0;
        end else if (asserted && timer_empty) begin
            next_throttle_assert_timer = TTA_TIMER_ONE;
        end else if (presc.tick && !timer_full) begin
            // A tick from the last asserted cycle still counts after release
            if (timer_at_one && !first_step) begin
                next_first_step = 1'b1;
            end else begin
                next_throttle_assert_timer = throttle_assert_timer + TTA_TIMER_ONE;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            throttle_assert_timer <= TTA_RST_BYTE;
            first_step            <= 1'b0;
        end else begin
            throttle_assert_timer <= next_throttle_assert_timer;
            first_step            <= next_first_step;
        end
    end

    // ==============================
    // Limit compare, sticky flag and alert
    logic over_limit;
    logic flag;
    logic next_flag;
    logic alert;
    logic next_alert_pin_oe_n;
    logic next_multi_pin_oe_n;
    logic next_full_speed;
    logic fan_running;
    logic alert_pin_oe_n;
    logic multi_pin_oe_n;
    logic full_speed;
    logic alert_pin_level;
    logic multi_pin_level;
    logic next_alert_pin_level;
    logic next_multi_pin_level;

    assign over_limit = monitor_en && (throttle_assert_timer > throttle_timer_limit);

    always_comb begin
        next_flag = flag;
        if (rd_status && !over_limit) begin
            next_flag = 1'b0;
        end
        if (over_limit) begin
            next_flag = 1'b1;
        end
    end

    assign alert       = flag && !mask_two[TTA_FLAG_BIT];
    assign fan_running = fan_auto_mode_i ? fan_above_start_i
                                         : (fan_manual_duty_i != TTA_DUTY_OFF);

    // Enable that pulls an open-drain alert line low
    function automatic logic drive_low_n(input logic active,
                                         input logic pin_en);
        return !(active && pin_en);
    endfunction

    always_comb begin
        next_alert_pin_oe_n  = drive_low_n(alert, config_three[TTA_C3_ALERT_EN_BIT]);
        next_multi_pin_oe_n  = drive_low_n(alert, pin_is_alert);
        // Open-drain lines only ever pull low
        next_alert_pin_level = 1'b0;
        next_multi_pin_level = 1'b0;
        next_full_speed      = config_three[TTA_C3_OVERRIDE_BIT] && pin_is_throttle
                               && !thermal_throttle_n && fan_running;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag            <= 1'b0;
            alert_pin_oe_n  <= 1'b1;
            multi_pin_oe_n  <= 1'b1;
            alert_pin_level <= 1'b0;
            multi_pin_level <= 1'b0;
            full_speed      <= 1'b0;
        end else begin
            flag            <= next_flag;
            alert_pin_oe_n  <= next_alert_pin_oe_n;
            multi_pin_oe_n  <= next_multi_pin_oe_n;
            alert_pin_level <= next_alert_pin_level;
            multi_pin_level <= next_multi_pin_level;
            full_speed      <= next_full_speed;
        end
    end

    // ==============================
    // Read data
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = rdata;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                TTA_ADDR_STATUS_TWO:   next_rdata = 8'(flag) << TTA_FLAG_BIT;
                TTA_ADDR_MASK_TWO:     next_rdata = mask_two;
                TTA_ADDR_CONFIG_THREE: next_rdata = config_three;
                TTA_ADDR_TIMER:        next_rdata = throttle_assert_timer;
                TTA_ADDR_TIMER_LIMIT:  next_rdata = throttle_timer_limit;
                TTA_ADDR_CONFIG_FOUR:  next_rdata = {6'h00, multi_pin_select};
                default:               next_rdata = TTA_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata <= TTA_RST_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==============================
    // Outputs
    assign reg_rdata_o             = rdata;
    assign multi_pin_o             = multi_pin_level;
    assign multi_pin_oe_n_o        = multi_pin_oe_n;
    assign alert_pin_o             = alert_pin_level;
    assign alert_pin_oe_n_o        = alert_pin_oe_n;
    assign full_speed_override_o   = full_speed;
    assign fan4_or_throttle_flag_o = flag;
endmodule
`default_nettype wire

// ===== tta_pkg.sv
// Constants and types for the thermal throttle timer and alert block
package tta_pkg;

    // ==============================
    // Register offsets
    localparam logic [7:0] TTA_ADDR_STATUS_TWO    = 8'h42;
    localparam logic [7:0] TTA_ADDR_MASK_TWO      = 8'h75;
    localparam logic [7:0] TTA_ADDR_CONFIG_THREE  = 8'h78;
    localparam logic [7:0] TTA_ADDR_TIMER         = 8'h79;
    localparam logic [7:0] TTA_ADDR_TIMER_LIMIT   = 8'h7a;
    localparam logic [7:0] TTA_ADDR_CONFIG_FOUR   = 8'h7d;

    // ==============================
    // Field positions
    localparam int TTA_C3_ALERT_EN_BIT  = 0;
    localparam int TTA_C3_TIMER_EN_BIT  = 1;
    localparam int TTA_C3_OVERRIDE_BIT  = 2;
    localparam int TTA_FLAG_BIT         = 5;
    localparam int TTA_SEL_LSB          = 0;
    localparam int TTA_SEL_MSB          = 1;

    // ==============================
    // Reset value and other byte constants
    localparam logic [7:0] TTA_RST_BYTE   = 8'h00;
    localparam logic [7:0] TTA_TIMER_FULL = 8'hff;
    localparam logic [7:0] TTA_TIMER_ONE  = 8'h01;
    localparam logic [7:0] TTA_DUTY_OFF   = 8'h00;

    // ==============================
    // Timing
    localparam real TTA_CLK_PERIOD_NS = 8.0;
    localparam real TTA_TICK_MS       = 22.76;
    localparam int  TTA_TICK_CYCLES   = int'(TTA_TICK_MS * 1.0e6 / TTA_CLK_PERIOD_NS);
    localparam int  TTA_PRESC_W       = 22;

    // ==============================
    // Multi-purpose pin functions
    typedef enum logic [1:0] {
        TTA_PIN_TACH     = 2'b00,
        TTA_PIN_THROTTLE = 2'b01,
        TTA_PIN_ALERT    = 2'b10,
        TTA_PIN_GPIO     = 2'b11
    } tta_pin_sel_t;

endpackage

// ===== tta_presc_if.sv
// Carrier between the main block and its tick prescaler
`timescale 1ns/100ps
`default_nettype none
interface tta_presc_if;
    logic run;
    logic clear;
    logic tick;

    modport master (output run, output clear, input tick);
    modport slave  (input run, input clear, output tick);
endinterface
`default_nettype wire

// ===== tta_prescaler.sv
// Prescaler giving one tick per timer count of asserted time
`timescale 1ns/100ps
`default_nettype none
module tta_prescaler #(
    parameter int TICK_CYCLES = tta_pkg::TTA_TICK_CYCLES,
    parameter int CNT_W       = tta_pkg::TTA_PRESC_W
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    // Control and tick
    tta_presc_if.slave      presc
);
    import tta_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] ZERO = '0;
    localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             tick;
    logic             next_tick;

    assign presc.tick = tick;

    // ==============================
    // Counting pauses while the input is released
    always_comb begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (presc.clear) begin
            next_cnt = ZERO;
        end else if (presc.run) begin
            if (cnt == LAST) begin
                next_cnt  = ZERO;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + ONE;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt  <= ZERO;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ===== tta_top_asserts.sv
// Port-level checks for the throttle timer block
`timescale 1ns/100ps
`default_nettype none
module tta_top_asserts (
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Pins and fan state
    input wire logic       multi_pin_i,
    input wire logic       multi_pin_o,
    input wire logic       multi_pin_oe_n_o,
    input wire logic       alert_pin_o,
    input wire logic       alert_pin_oe_n_o,
    input wire logic [7:0] fan_manual_duty_i,
    input wire logic       fan_auto_mode_i,
    input wire logic       fan_above_start_i,
    input wire logic       full_speed_override_o,
    input wire logic       fan4_or_throttle_flag_o
);
    import tta_pkg::*;
    // ====================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_alert_from_flag: assert property (
        $fell(alert_pin_oe_n_o) |-> $past(fan4_or_throttle_flag_o)) else $error("alert without flag");
    a_mpin_from_flag: assert property (
        $fell(multi_pin_oe_n_o) |-> $past(fan4_or_throttle_flag_o)) else $error("pin alert no flag");
    a_open_drain: assert property (
        multi_pin_o == 1'b0 && alert_pin_o == 1'b0) else $error("open drain level driven high");
    a_flag_sticky: assert property (
        $fell(fan4_or_throttle_flag_o) |-> $past(reg_rd_i && reg_addr_i == TTA_ADDR_STATUS_TWO))
        else $error("flag cleared without status read");
    a_rdata_stands: assert property (
        !$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("read data changed without read");
    a_ovr_running: assert property (
        full_speed_override_o |->
        $past(fan_auto_mode_i ? fan_above_start_i : fan_manual_duty_i != TTA_DUTY_OFF))
        else $error("override on idle fan");
    a_ovr_pin_idle: assert property (
        multi_pin_i [*5] |-> !full_speed_override_o) else $error("override with pin released");
    a_limit_rdback: assert property (
        reg_wr_i && reg_addr_i == TTA_ADDR_TIMER_LIMIT ##1
        reg_rd_i && reg_addr_i == TTA_ADDR_TIMER_LIMIT |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("limit readback mismatch");
    a_release_no_flag: assert property (
        !fan4_or_throttle_flag_o |=> alert_pin_oe_n_o && multi_pin_oe_n_o)
        else $error("alert line held without flag");
endmodule
bind tta_top tta_top_asserts u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .multi_pin_i(multi_pin_i), .multi_pin_o(multi_pin_o), .multi_pin_oe_n_o(multi_pin_oe_n_o),
    .alert_pin_o(alert_pin_o), .alert_pin_oe_n_o(alert_pin_oe_n_o),
    .fan_manual_duty_i(fan_manual_duty_i), .fan_auto_mode_i(fan_auto_mode_i),
    .fan_above_start_i(fan_above_start_i), .full_speed_override_o(full_speed_override_o),
    .fan4_or_throttle_flag_o(fan4_or_throttle_flag_o));
`default_nettype wire

// ===== tta_hot_model.sv
// Processor hot output driving the throttle pin
`timescale 1ns/100ps
`default_nettype none
module tta_hot_model (
    // Clock
    input  wire logic mclk_i,
    // Request and pin
    input  wire logic hot_req_i,
    output var  logic hot_pin_o
);
    logic pull_low = 1'b0;
    // Open drain: line returns to the pull-up level when released
    always_ff @(posedge mclk_i) begin
        pull_low <= hot_req_i;
    end
    assign hot_pin_o = !pull_low;
endmodule
`default_nettype wire

// ===== thermal_throttle_timer_alert_tb.sv
// Self-checking bench for the throttle timer block
`timescale 1ns/100ps
`default_nettype none
module thermal_throttle_timer_alert_tb;
    import tta_pkg::*;
    logic       mclk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       hot_req = 1'b0;
    logic       pin;
    logic       mpo, mpoe_n, apo, apoe_n, ovr, flag;
    logic [7:0] duty = 8'h00;
    logic       auto_m = 1'b0;
    logic       above = 1'b0;
    logic       rd_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] adr_q[$];
    logic [7:0] v;
    logic [7:0] map[6] = '{TTA_ADDR_STATUS_TWO, TTA_ADDR_MASK_TWO, TTA_ADDR_CONFIG_THREE,
                           TTA_ADDR_TIMER, TTA_ADDR_TIMER_LIMIT, TTA_ADDR_CONFIG_FOUR};
    // Override cases: override bit, auto, above start, duty set, expected
    logic [4:0] ovt[5] = '{5'b10011, 5'b10000, 5'b11101, 5'b11010, 5'b00010};
    int         fail_count = 0;
    int         compares = 0;
    always #4 mclk_i = ~mclk_i;
    tta_hot_model u_hot (.mclk_i(mclk_i), .hot_req_i(hot_req), .hot_pin_o(pin));
    tta_top #(.TICK_CYCLES(10)) u_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .multi_pin_i(pin),
        .multi_pin_o(mpo), .multi_pin_oe_n_o(mpoe_n), .alert_pin_o(apo),
        .alert_pin_oe_n_o(apoe_n), .fan_manual_duty_i(duty), .fan_auto_mode_i(auto_m),
        .fan_above_start_i(above), .full_speed_override_o(ovr),
        .fan4_or_throttle_flag_o(flag));
    // ====================
    // Tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        wt(1);
        wr = 1'b0;
        wt(1);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        addr = a;
        rd = 1'b1;
        wt(1);
        rd = 1'b0;
        wt(1);
    endtask
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        wt(1);
        wr = 1'b0;
        rd_reg(a, d);
    endtask
    task automatic hot(input int n);
        hot_req = 1'b1;
        wt(n);
        hot_req = 1'b0;
        wt(8);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Read results are compared against the oldest note
    always @(posedge mclk_i) begin
        if (rd_d) begin
            chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rdata);
        end
        rd_d <= rd;
    end
    initial begin
        wt(20000);
        fail_count++;
        complete_run();
    end
    // ====================
    // Main sequence
    initial begin
        v = 8'($urandom(38957));
        wt(12);
        rst_b_i = 1'b1;
        foreach (map[i]) rd_reg(map[i], TTA_RST_BYTE);
        rd_reg(8'h55, 8'h00);
        wr_reg(TTA_ADDR_STATUS_TWO, 8'hff);
        rd_reg(TTA_ADDR_STATUS_TWO, 8'h00);
        wr_reg(TTA_ADDR_TIMER, 8'h5a);
        rd_reg(TTA_ADDR_TIMER, 8'h00);
        chk("alert", 8'h01, 8'(apoe_n));
        wr_reg(TTA_ADDR_CONFIG_THREE, 8'h02);
        hot(30);
        rd_reg(TTA_ADDR_TIMER, 8'h00);
        wr_reg(TTA_ADDR_CONFIG_THREE, 8'h00);
        wr_reg(TTA_ADDR_CONFIG_FOUR, 8'h01);
        hot(30);
        rd_reg(TTA_ADDR_TIMER, 8'h00);
        wr_reg(TTA_ADDR_TIMER_LIMIT, 8'hff);
        wr_reg(TTA_ADDR_CONFIG_THREE, 8'h03);
        hot(25);
        hot(30);
        rd_reg(TTA_ADDR_TIMER, 8'h05);
        rd_reg(TTA_ADDR_TIMER, 8'h00);
        hot(10);
        hot(10);
        rd_reg(TTA_ADDR_TIMER, 8'h02);
        hot_req = 1'b1;
        wt(35);
        rd_reg(TTA_ADDR_TIMER, 8'h03);
        rd_reg(TTA_ADDR_TIMER, 8'h01);
        wt(32);
        hot_req = 1'b0;
        wt(8);
        rd_reg(TTA_ADDR_TIMER, 8'h03);
        hot(2700);
        rd_reg(TTA_ADDR_TIMER, TTA_TIMER_FULL);
        wr_reg(TTA_ADDR_TIMER_LIMIT, 8'h00);
        hot(5);
        chk("flag", 8'h01, 8'(flag));
        chk("alert", 8'h00, 8'(apoe_n));
        rd_reg(TTA_ADDR_STATUS_TWO, 8'h20);
        chk("flag", 8'h01, 8'(flag));
        rd_reg(TTA_ADDR_TIMER, 8'h01);
        rd_reg(TTA_ADDR_STATUS_TWO, 8'h20);
        chk("flag", 8'h00, 8'(flag));
        chk("alert", 8'h01, 8'(apoe_n));
        wrrd(TTA_ADDR_MASK_TWO, 8'($urandom) | 8'h20);
        hot(5);
        chk("flag", 8'h01, 8'(flag));
        chk("alert", 8'h01, 8'(apoe_n));
        wrrd(TTA_ADDR_MASK_TWO, 8'h00);
        chk("alert", 8'h00, 8'(apoe_n));
        for (int s = 0; s < 4; s++) begin
            wr_reg(TTA_ADDR_CONFIG_FOUR, 8'(s));
            chk("pin alert", 8'(s != 2), 8'(mpoe_n));
        end
        wr_reg(TTA_ADDR_CONFIG_THREE, 8'h02);
        chk("alert", 8'h01, 8'(apoe_n));
        wr_reg(TTA_ADDR_CONFIG_FOUR, 8'h01);
        wr_reg(TTA_ADDR_CONFIG_THREE, 8'h03);
        rd_reg(TTA_ADDR_TIMER, 8'h01);
        rd_reg(TTA_ADDR_STATUS_TWO, 8'h20);
        wr_reg(TTA_ADDR_TIMER_LIMIT, 8'h01);
        hot(16);
        chk("flag", 8'h00, 8'(flag));
        hot(16);
        chk("flag", 8'h01, 8'(flag));
        rd_reg(TTA_ADDR_TIMER, 8'h03);
        rd_reg(TTA_ADDR_STATUS_TWO, 8'h20);
        wrrd(TTA_ADDR_TIMER_LIMIT, v);
        repeat (4) wrrd(TTA_ADDR_TIMER_LIMIT, 8'($urandom));
        wrrd(TTA_ADDR_TIMER_LIMIT, 8'hff);
        foreach (ovt[k]) begin
            auto_m = ovt[k][3];
            above = ovt[k][2];
            duty = ovt[k][1] ? 8'($urandom_range(255, 1)) : 8'h00;
            wr_reg(TTA_ADDR_CONFIG_THREE, {5'h00, ovt[k][4], 2'b11});
            hot_req = 1'b1;
            wt(6);
            chk("override", 8'(ovt[k][0]), 8'(ovr));
            hot_req = 1'b0;
            wt(6);
            chk("override", 8'h00, 8'(ovr));
        end
        wt(4);
        complete_run();
    end
endmodule
`default_nettype wire
